// ==== logic/dsl_pkg.sv ====
/*
 * dsl_pkg: constants shared by the serial load control block.
 * Assumes the serial frame is 16 bits, MSB first, with a 12-bit converter code.
 */
package dsl_pkg;

	// serial frame layout
	localparam int FRAME_BITS    = 16;
	localparam int CODE_BITS     = 12;
	localparam int CTRL_BITS     = 8;
	localparam int FRM_RD_BIT    = 15;
	localparam int FRM_ADDR_HI   = 14;
	localparam int FRM_ADDR_LO   = 12;
	localparam int CNT_W         = 5;
	localparam logic [CNT_W-1:0] LAST_EDGE = 5'h0F;

	// frame register addresses
	localparam logic [2:0] FA_NOP     = 3'h0;
	localparam logic [2:0] FA_DAC     = 3'h1;
	localparam logic [2:0] FA_CTRL    = 3'h2;

	// control register fields and reset values
	localparam int CTRL_PWR_BIT   = 2;
	localparam int CTRL_CLAMP_BIT = 6;
	localparam logic [CTRL_BITS-1:0] CTRL_RST = 8'h40;
	localparam logic [CODE_BITS-1:0] CODE_ZERO = 12'h000;

	// bus register byte offsets
	localparam logic [4:0] OFS_STATUS = 5'h00;
	localparam logic [4:0] OFS_MASK   = 5'h04;
	localparam logic [4:0] OFS_CODES  = 5'h08;
	localparam logic [4:0] OFS_STATE  = 5'h0C;

	// status / mask bit positions
	localparam int EV_WRITE = 0;
	localparam int EV_ABORT = 1;
	localparam int EV_CLEAR = 2;
	localparam int EV_LOAD  = 3;
	localparam int EV_HOT   = 4;
	localparam int EV_BITS  = 5;
	localparam logic [EV_BITS-1:0] MASK_RST = 5'h00;

	// synchronised pin positions
	localparam int PIN_SCLK  = 0;
	localparam int PIN_SYNC  = 1;
	localparam int PIN_SDAT  = 2;
	localparam int PIN_LOAD  = 3;
	localparam int PIN_CLR   = 4;
	localparam int PIN_RANGE = 5;
	localparam int PIN_HOT   = 6;
	localparam int PIN_COUNT = 7;
	localparam logic [PIN_COUNT-1:0] PIN_RST = 7'h1A;

endpackage : dsl_pkg

// ==== logic/dsl_pin_if.sv ====
/*
 * dsl_pin_if: synchronised pin levels and their edge pulses.
 * Assumes one clock domain on both sides.
 */
`timescale 1ns/1ns
interface dsl_pin_if #(parameter int N = dsl_pkg::PIN_COUNT);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;

	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : dsl_pin_if

// ==== logic/dsl_pin_sync.sv ====
/*
 * dsl_pin_sync: two-flop synchroniser bank with edge detection.
 * Assumes all inputs are asynchronous to clk; levels settle to PIN_RST in reset.
 */
`timescale 1ns/1ns
module dsl_pin_sync #(
	parameter int N = dsl_pkg::PIN_COUNT
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [N-1:0] pins,
	dsl_pin_if.src            sync_o
);
	logic [N-1:0] meta_r;
	logic [N-1:0] stab_r;
	logic [N-1:0] last_r;

	////////////////////////////////////////////////////////////////////////////
	// meta_r feeds only stab_r
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= dsl_pkg::PIN_RST;
			stab_r <= dsl_pkg::PIN_RST;
			last_r <= dsl_pkg::PIN_RST;
		end else begin
			meta_r <= pins;
			stab_r <= meta_r;
			last_r <= stab_r;
		end
	end

	assign sync_o.level = stab_r;
	assign sync_o.rise  = stab_r & ~last_r;
	assign sync_o.fall  = ~stab_r & last_r;

endmodule : dsl_pin_sync

// ==== logic/dsl_load_ctrl.sv ====
/*
 * dsl_load_ctrl: serial frame receiver, input and converter registers,
 * clear and load handling, power control and an Avalon-MM status slave.
 * Assumes sclk is at most a few MHz so clk can oversample it; all pins
 * are asynchronous and pass through dsl_pin_sync first.
 */
`timescale 1ns/1ns
// Operation
// - falling clear edge clears regardless of shift clock
// - clear held low blocks every load
// - clear sets input and converter codes to zero
// - shift register enabled only while sync low
// - 16-bit shift register, sample on falling edge
// - update register at sixteenth falling edge
// - early sync rise aborts, nothing changes
// - readback changes on rising edges
// - load strobe low pulse copies input register
// - strobe held low loads after each write
// - range pin low selects 60 V span
// - alarm output low while die overheated
// - reset: control 0x40, codes zero
// - power bit controls analog, registers stay live
// - clamp bit picks three-state or ground
// - overheat power-down stays until software power-up
module dsl_load_ctrl (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        sclk,
	input  wire logic        sync_n,
	input  wire logic        serial_in,
	output logic             serial_out,
	input  wire logic        load_strobe_n,
	input  wire logic        async_clear_n,
	input  wire logic        range_select,
	input  wire logic        over_temp,
	output logic             alarm_n,
	output logic             span_60v,
	output logic             analog_power_on,
	output logic             output_hiz,
	output logic             output_ground,
	output logic [11:0]      dac_code,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq
);
	localparam int FB = dsl_pkg::FRAME_BITS;
	localparam int CB = dsl_pkg::CODE_BITS;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} dsl_frame_e;

	function automatic logic [2:0] frame_addr(input logic [FB-1:0] w);
		frame_addr = w[dsl_pkg::FRM_ADDR_HI:dsl_pkg::FRM_ADDR_LO];
	endfunction : frame_addr

	dsl_pin_if #(.N(dsl_pkg::PIN_COUNT)) pin_s ();

	logic [dsl_pkg::PIN_COUNT-1:0] pins_raw;
	assign pins_raw = {over_temp, range_select, async_clear_n, load_strobe_n,
		serial_in, sync_n, sclk};

	// every pin, shift clock included, crosses two flops before use
	dsl_pin_sync #(.N(dsl_pkg::PIN_COUNT)) u_sync (
		.clk    (clk),
		.nrst   (nrst),
		.pins   (pins_raw),
		.sync_o (pin_s)
	);

	logic sclk_rise, sclk_fall, sync_fall, sync_rise, sync_lvl, sdat;
	logic load_lvl, load_fall, clr_lvl, clr_fall, hot_lvl, hot_rise;
	assign sclk_rise = pin_s.rise[dsl_pkg::PIN_SCLK];
	assign sclk_fall = pin_s.fall[dsl_pkg::PIN_SCLK];
	assign sync_fall = pin_s.fall[dsl_pkg::PIN_SYNC];
	assign sync_rise = pin_s.rise[dsl_pkg::PIN_SYNC];
	assign sync_lvl  = pin_s.level[dsl_pkg::PIN_SYNC];
	assign sdat      = pin_s.level[dsl_pkg::PIN_SDAT];
	assign load_lvl  = pin_s.level[dsl_pkg::PIN_LOAD];
	assign load_fall = pin_s.fall[dsl_pkg::PIN_LOAD];
	assign clr_lvl   = pin_s.level[dsl_pkg::PIN_CLR];
	assign clr_fall  = pin_s.fall[dsl_pkg::PIN_CLR];
	assign hot_lvl   = pin_s.level[dsl_pkg::PIN_HOT];
	assign hot_rise  = pin_s.rise[dsl_pkg::PIN_HOT];

	dsl_frame_e                     state_r;
	logic [FB-1:0]                  shift_r;
	logic [dsl_pkg::CNT_W-1:0]      cnt_r;
	logic [FB-1:0]                  out_sh_r;
	logic [FB-1:0]                  rb_buf_r;
	logic [CB-1:0]                  input_r;
	logic [CB-1:0]                  dac_r;
	logic [dsl_pkg::CTRL_BITS-1:0]  ctrl_r;
	logic [dsl_pkg::EV_BITS-1:0]    status_r;
	logic [dsl_pkg::EV_BITS-1:0]    mask_r;
	logic                           ack_r;

	////////////////////////////////////////////////////////////////////////////
	// frame receiver
	logic [FB-1:0] word_nxt;
	logic          frame_done;
	logic          frame_abort;
	logic          wr_dac;
	logic          wr_ctrl;
	logic          rd_req;

	// cnt_r only moves in shift; stray edges outside a frame do nothing
	assign word_nxt    = {shift_r[FB-2:0], sdat};
	assign frame_done  = (state_r == ST_SHIFT) && !sync_lvl && sclk_fall
		&& (cnt_r == dsl_pkg::LAST_EDGE);
	assign frame_abort = (state_r == ST_SHIFT) && sync_rise;
	assign rd_req  = frame_done && word_nxt[dsl_pkg::FRM_RD_BIT];
	assign wr_dac  = frame_done && !word_nxt[dsl_pkg::FRM_RD_BIT]
		&& (frame_addr(word_nxt) == dsl_pkg::FA_DAC);
	assign wr_ctrl = frame_done && !word_nxt[dsl_pkg::FRM_RD_BIT]
		&& (frame_addr(word_nxt) == dsl_pkg::FA_CTRL);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
			shift_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (sync_fall) begin
						state_r <= ST_SHIFT;
						cnt_r   <= '0;
					end
				end
				ST_SHIFT: begin
					if (sync_rise) begin
						state_r <= ST_IDLE;
					end else if (sclk_fall) begin
						shift_r <= word_nxt;
						cnt_r   <= cnt_r + 5'h01;
						if (cnt_r == dsl_pkg::LAST_EDGE) begin
							state_r <= ST_IDLE;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// readback: a read frame primes the word shifted out in the next frame
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rb_buf_r <= '0;
		end else if (rd_req) begin
			case (frame_addr(word_nxt))
				dsl_pkg::FA_DAC:  rb_buf_r <= {1'b0, dsl_pkg::FA_DAC, dac_r};
				dsl_pkg::FA_CTRL: rb_buf_r <= {1'b0, dsl_pkg::FA_CTRL, 4'h0, ctrl_r};
				default:          rb_buf_r <= {1'b0, frame_addr(word_nxt), 12'h000};
			endcase
		end
	end

	// first bit stands from sync fall; later bits move on rising edges only
	// after a falling edge, so the host never misses the MSB
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_sh_r <= '0;
		end else if (state_r == ST_IDLE && sync_fall) begin
			out_sh_r <= rb_buf_r;
		end else if (state_r == ST_SHIFT && !sync_lvl && sclk_rise
			&& cnt_r != 5'h00) begin
			out_sh_r <= {out_sh_r[FB-2:0], 1'b0};
		end
	end

	assign serial_out = out_sh_r[FB-1];

	////////////////////////////////////////////////////////////////////////////
	// input and converter registers
	// clear outranks both load paths; writes still land in input_r
	logic load_ok;
	logic do_load;
	assign load_ok = clr_lvl;
	assign do_load = load_ok && (load_fall || (wr_dac && !load_lvl));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			input_r <= dsl_pkg::CODE_ZERO;
		end else if (clr_fall) begin
			input_r <= dsl_pkg::CODE_ZERO;
		end else if (wr_dac) begin
			input_r <= word_nxt[CB-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dac_r <= dsl_pkg::CODE_ZERO;
		end else if (clr_fall) begin
			dac_r <= dsl_pkg::CODE_ZERO;
		end else if (do_load) begin
			dac_r <= wr_dac ? word_nxt[CB-1:0] : input_r;
		end
	end

	assign dac_code = dac_r;

	////////////////////////////////////////////////////////////////////////////
	// control register and power
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= dsl_pkg::CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= word_nxt[dsl_pkg::CTRL_BITS-1:0];
			end
			// overheat wins; power-up is refused while still hot
			if (hot_rise || (hot_lvl && wr_ctrl)) begin
				ctrl_r[dsl_pkg::CTRL_PWR_BIT] <= 1'b0;
			end
		end
	end

	// alarm follows the level, the power-down latches until software
	logic powered;
	assign powered         = ctrl_r[dsl_pkg::CTRL_PWR_BIT];
	assign analog_power_on = powered;
	assign output_hiz      = !powered && ctrl_r[dsl_pkg::CTRL_CLAMP_BIT];
	assign output_ground   = !powered && !ctrl_r[dsl_pkg::CTRL_CLAMP_BIT];
	assign span_60v        = !pin_s.level[dsl_pkg::PIN_RANGE];
	assign alarm_n         = !hot_lvl;

	////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, answer on the second edge
	// a fixed single wait keeps readdata registered at little cost
	logic bus_req;
	logic bus_rd_done;
	logic bus_wr_done;
	assign bus_req         = avs_read || avs_write;
	assign avs_waitrequest = bus_req && !ack_r;
	assign bus_rd_done     = avs_read && ack_r;
	assign bus_wr_done     = avs_write && ack_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req && !ack_r;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= '0;
		end else if (avs_read && !ack_r) begin
			case (avs_address)
				dsl_pkg::OFS_STATUS: avs_readdata <= {27'h0, status_r};
				dsl_pkg::OFS_MASK:   avs_readdata <= {27'h0, mask_r};
				dsl_pkg::OFS_CODES:  avs_readdata <= {4'h0, input_r, 4'h0, dac_r};
				dsl_pkg::OFS_STATE:  avs_readdata <= {20'h00000, !hot_lvl,
					pin_s.level[dsl_pkg::PIN_RANGE], !clr_lvl, !load_lvl, ctrl_r};
				default:             avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_r <= dsl_pkg::MASK_RST;
		end else if (bus_wr_done && avs_address == dsl_pkg::OFS_MASK) begin
			mask_r <= avs_writedata[dsl_pkg::EV_BITS-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky events; a set in the clearing cycle survives
	logic [dsl_pkg::EV_BITS-1:0] ev_set;
	always_comb begin
		ev_set = '0;
		ev_set[dsl_pkg::EV_WRITE] = frame_done;
		ev_set[dsl_pkg::EV_ABORT] = frame_abort;
		ev_set[dsl_pkg::EV_CLEAR] = clr_fall;
		ev_set[dsl_pkg::EV_LOAD]  = do_load;
		ev_set[dsl_pkg::EV_HOT]   = hot_rise;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_r <= '0;
		end else if (bus_rd_done && avs_address == dsl_pkg::OFS_STATUS) begin
			status_r <= ev_set;
		end else begin
			status_r <= status_r | ev_set;
		end
	end

	assign irq = |(status_r & mask_r);

endmodule : dsl_load_ctrl

// ==== test/dsl_host_model.sv ====
/* dsl_host_model: behavioural host framing words onto the serial pins.
 * Assumes a 125 ns shift clock that stands low between frames. */
`timescale 1ns/1ns
module dsl_host_model (
	output logic      sclk,
	output logic      sync_n,
	output logic      serial_in,
	input  wire logic serial_out
);
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		serial_in = 1'b0;
	end
	// nb below 16 cuts the frame short on purpose
	task automatic frame(logic [15:0] w, int nb, output logic [15:0] rd);
		rd = 16'h0000;
		sync_n = 1'b0;
		#60;
		for (int i = 0; i < nb; i++) begin
			sclk = 1'b1;
			// data moves mid-high, so a rising-edge sampler would see the old bit
			#30;
			serial_in = w[15-i];
			#32;
			sclk = 1'b0;
			rd = {rd[14:0], serial_out};
			#63;
		end
		sync_n = 1'b1;
		// released line must not look held
		serial_in = ~serial_in;
		#40;
	endtask : frame
endmodule : dsl_host_model

// ==== test/dsl_load_ctrl_chk.sv ====
/* dsl_load_ctrl_chk: port properties of the load control block.
 * Assumes pins pass a synchroniser of two to three clk cycles. */
`timescale 1ns/1ns
module dsl_load_ctrl_chk (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        async_clear_n,
	input wire logic        range_select,
	input wire logic        over_temp,
	input wire logic        alarm_n,
	input wire logic        span_60v,
	input wire logic        analog_power_on,
	input wire logic        output_hiz,
	input wire logic        output_ground,
	input wire logic [11:0] dac_code,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	property p_rst_state;
		$rose(nrst) |-> dac_code == 12'h000 && !analog_power_on && output_hiz;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
	property p_clr_zero;
		$fell(async_clear_n) |-> ##[1:8] dac_code == 12'h000;
	endproperty
	a_clr_zero: assert property (p_clr_zero) else $error("clear not zeroing");
	property p_clr_hold;
		(!async_clear_n)[*8] |-> $stable(dac_code);
	endproperty
	a_clr_hold: assert property (p_clr_hold) else $error("load during clear");
	property p_span;
		$fell(range_select) |-> ##[1:5] span_60v;
	endproperty
	a_span: assert property (p_span) else $error("span not 60");
	property p_alarm;
		$rose(over_temp) |-> ##[1:5] !alarm_n;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm not raised");
	property p_hot_down;
		$rose(over_temp) |-> ##[1:8] !analog_power_on;
	endproperty
	a_hot_down: assert property (p_hot_down) else $error("no hot power-down");
	property p_hot_lock;
		!alarm_n |-> !$rose(analog_power_on);
	endproperty
	a_hot_lock: assert property (p_hot_lock) else $error("powered up while hot");
	property p_down_out;
		!analog_power_on |-> output_hiz != output_ground;
	endproperty
	a_down_out: assert property (p_down_out) else $error("down output wrong");
	property p_up_out;
		analog_power_on |-> !output_hiz && !output_ground;
	endproperty
	a_up_out: assert property (p_up_out) else $error("up output clamped");
	property p_bus_wait;
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus wait wrong");
	c_clear: cover property ($fell(async_clear_n));
	c_hot: cover property ($fell(alarm_n));
	c_up: cover property ($rose(analog_power_on));
endmodule : dsl_load_ctrl_chk
bind dsl_load_ctrl dsl_load_ctrl_chk u_dsl_load_ctrl_chk (.*);

// ==== test/dsl_load_ctrl_tb.sv ====
/* dsl_load_ctrl_tb: scenario bench for the load control block.
 * Assumes the host model owns the serial pins; the bench drives the rest. */
`timescale 1ns/1ns
module dsl_load_ctrl_tb;
	logic        clk, nrst, sclk, sync_n, serial_in, serial_out;
	logic        load_strobe_n, async_clear_n, range_select, over_temp;
	logic        alarm_n, span_60v, analog_power_on, output_hiz, output_ground;
	logic        avs_read, avs_write, avs_waitrequest, irq;
	logic [11:0] dac_code;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] rd;
	int          miscompares, n_tests, cyc;
	dsl_load_ctrl u_dsl_load_ctrl (.*);
	dsl_host_model u_dsl_host_model (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	task automatic bus(bit w, logic [4:0] a, logic [31:0] d = 32'h0);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic fr(logic [15:0] w, int nb = 16);
		u_dsl_host_model.frame(w, nb, rd);
		repeat (10) @(posedge clk);
	endtask : fr
	task automatic strobe;
		@(posedge clk);
		load_strobe_n <= 1'b0;
		repeat (8) @(posedge clk);
		load_strobe_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask : strobe
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	task automatic t_reset;
		chk("hiz", 32'h1, 32'(output_hiz));
		bus(1'b0, dsl_pkg::OFS_STATE);
		chk("ctrl", 32'(dsl_pkg::CTRL_RST), 32'(q[7:0]));
		bus(1'b0, dsl_pkg::OFS_CODES);
		chk("codes", 32'h0, q);
		bus(1'b0, 5'h10);
		chk("unmapped", 32'h0, q);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_write_load;
		bus(1'b1, dsl_pkg::OFS_MASK, 32'h1);
		bus(1'b0, dsl_pkg::OFS_MASK);
		chk("mask", 32'h1, q);
		bus(1'b0, dsl_pkg::OFS_STATUS);
		fr(16'h1A5C);
		chk("irq", 32'h1, 32'(irq));
		bus(1'b0, dsl_pkg::OFS_CODES);
		chk("codes", 32'h0A5C0000, q);
		bus(1'b0, dsl_pkg::OFS_STATUS);
		@(posedge clk);
		chk("write ev", 32'h1, 32'(q[0]));
		chk("irq off", 32'h0, 32'(irq));
		strobe();
		chk("dac", 32'h0A5C, 32'(dac_code));
		fr(16'h1123, 9);
		bus(1'b0, dsl_pkg::OFS_STATUS);
		chk("abort ev", 32'h1, 32'(q[1]));
		chk("load ev", 32'h1, 32'(q[dsl_pkg::EV_LOAD]));
		bus(1'b0, dsl_pkg::OFS_CODES);
		chk("kept", 32'h0A5C0A5C, q);
		$display("t_write_load done");
	endtask : t_write_load
	task automatic t_auto_clear;
		@(posedge clk);
		load_strobe_n <= 1'b0;
		fr(16'h17FF);
		chk("auto", 32'h07FF, 32'(dac_code));
		@(posedge clk);
		load_strobe_n <= 1'b1;
		async_clear_n <= 1'b0;
		repeat (10) @(posedge clk);
		bus(1'b0, dsl_pkg::OFS_CODES);
		chk("cleared", 32'h0, q);
		bus(1'b0, dsl_pkg::OFS_STATUS);
		chk("clear ev", 32'h1, 32'(q[dsl_pkg::EV_CLEAR]));
		fr(16'h1123);
		strobe();
		chk("blocked", 32'h0, 32'(dac_code));
		@(posedge clk);
		async_clear_n <= 1'b1;
		$display("t_auto_clear done");
	endtask : t_auto_clear
	task automatic t_ctrl;
		fr(16'h2000);
		chk("gnd", 32'h1, 32'(output_ground));
		fr(16'h2044);
		chk("up", 32'h1, 32'(analog_power_on));
		chk("unclamped", 32'h0, 32'(output_hiz | output_ground));
		fr(16'hA000);
		fr(16'h0000);
		chk("readback", 32'h2044, 32'(rd));
		fr(16'h9000);
		fr(16'h0000);
		chk("dac readback", 32'h1000, 32'(rd));
		$display("t_ctrl done");
	endtask : t_ctrl
	task automatic t_temp;
		@(posedge clk);
		range_select <= 1'b0;
		over_temp <= 1'b1;
		repeat (10) @(posedge clk);
		chk("span60", 32'h1, 32'(span_60v));
		chk("alarm", 32'h0, 32'(alarm_n));
		chk("hot down", 32'h0, 32'(analog_power_on));
		bus(1'b0, dsl_pkg::OFS_STATUS);
		chk("hot ev", 32'h1, 32'(q[dsl_pkg::EV_HOT]));
		fr(16'h2044);
		chk("refused", 32'h0, 32'(analog_power_on));
		@(posedge clk);
		range_select <= 1'b1;
		over_temp <= 1'b0;
		repeat (10) @(posedge clk);
		chk("span30", 32'h0, 32'(span_60v));
		chk("alarm off", 32'h1, 32'(alarm_n));
		chk("stays down", 32'h0, 32'(analog_power_on));
		fr(16'h2044);
		chk("up again", 32'h1, 32'(analog_power_on));
		$display("t_temp done");
	endtask : t_temp
	////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end
	initial begin
		nrst = 1'b0;
		load_strobe_n = 1'b1;
		async_clear_n = 1'b1;
		range_select = 1'b1;
		over_temp = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		fork
			begin
				repeat (8) @(posedge clk);
				nrst <= 1'b1;
				@(posedge clk);
				t_reset();
				t_write_load();
				t_auto_clear();
				t_ctrl();
				t_temp();
			end
			begin
				// ceiling far above the few thousand cycles the scenarios need
				wait (cyc == 40000);
				$display("[FAIL] cycle limit exp below %0d got %0d", 40000, cyc);
				miscompares++;
			end
		join_any
		give_verdict();
	end
endmodule : dsl_load_ctrl_tb
